/* hdl/pwea_regs.svh */
// Register indices, field positions, reset values and masks of the wake event aggregator.
// Assumes a 32-bit APB slave where the byte address is four times the register index.
`ifndef PWEA_REGS_SVH
`define PWEA_REGS_SVH

// ************************************************************
// Register indices
// ************************************************************
`define PWEA_IDX_ACTIVATE   8'h30
`define PWEA_IDX_IRQ_SEL    8'h70
`define PWEA_IDX_HM_RST_SEL 8'he7
`define PWEA_IDX_RST_CTRL   8'hf2
`define PWEA_IDX_STAT_LO    8'hf3
`define PWEA_IDX_STAT_HI    8'hf4
`define PWEA_IDX_EN_LO      8'hf6
`define PWEA_IDX_EN_HI      8'hf7
`define PWEA_IDX_INT_STAT   8'hd0
`define PWEA_IDX_INT_EN     8'hd1
`define PWEA_IDX_INT_CLR    8'hd2

// ************************************************************
// Reset values and writable masks
// ************************************************************
`define PWEA_RST_CTRL_INIT  8'h7c
`define PWEA_RST_CTRL_MASK  8'h7d
`define PWEA_ZERO_INIT      8'h00
`define PWEA_STAT_LO_W      6
`define PWEA_STAT_HI_W      4
`define PWEA_IRQ_SEL_W      4
`define PWEA_INT_W          2

// ************************************************************
// Field positions
// ************************************************************
`define PWEA_CTRL_GWE       0
`define PWEA_CTRL_RST_LSB   2
`define PWEA_RST_OUT_N      5
`define PWEA_HM_SEL_BIT     0
`define PWEA_ACT_BIT        0
`define PWEA_INT_WAKE       0
`define PWEA_INT_BUSERR     1

`endif

/* hdl/pwea_pkg.sv */
// Types shared by the wake event aggregator and its bench.
// Assumes pwea_regs.svh supplies the widths.
`include "pwea_regs.svh"

package pwea_pkg;
   typedef logic [7:0]                    pwea_byte_t;
   typedef logic [`PWEA_STAT_LO_W-1:0]    pwea_src_lo_t;
   typedef logic [`PWEA_STAT_HI_W-1:0]    pwea_src_hi_t;
   typedef logic [`PWEA_RST_OUT_N-1:0]    pwea_rst_t;
   typedef logic [`PWEA_INT_W-1:0]        pwea_int_t;
   typedef logic [31:0]                   pwea_word_t;
endpackage : pwea_pkg

/* hdl/pwea_sync.sv */
// Two flip-flop level synchroniser, one chain per bit.
// Assumes the inputs are levels that stay put for at least two clocks.
`timescale 1ns/1ns

module pwea_sync #(
   parameter int             W    = 1,
   parameter logic [W-1:0]   INIT = '0
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_q;

   // ************************************************************
   // One chain per bit
   // ************************************************************
   for (genvar i = 0; i < W; i++)
   begin : g_bit
      always_ff @(posedge clk or negedge rst_n)
      begin
         if (!rst_n)
         begin
            meta_q[i] <= INIT[i];
            q[i]      <= INIT[i];
         end
         else
         begin
            meta_q[i] <= d[i];
            q[i]      <= meta_q[i];
         end
      end
   end

endmodule // pwea_sync

/* hdl/pwea_top.sv */
// Wake event aggregator: ten latched sources, enables and the wake request.
// Assumes an APB master, source levels from foreign clocks and a separate
// standby reset for the registers that live on standby power.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`include "pwea_regs.svh"

module pwea_top (
   // Clock and resets
   input  wire logic                 CLK,
   input  wire logic                 NRST,
   input  wire logic                 STBY_NRST,
   // APB slave
   input  wire logic                 PSEL,
   input  wire logic                 PENABLE,
   input  wire logic                 PWRITE,
   input  wire logic [9:0]           PADDR,
   input  wire pwea_pkg::pwea_word_t PWDATA,
   output pwea_pkg::pwea_word_t      PRDATA,
   output logic                      PREADY,
   output logic                      PSLVERR,
   // Event sources, active high except the watchdog
   input  wire logic                 SRC_MOUSE,
   input  wire logic                 SRC_KEYBOARD_CONTROLLER,
   input  wire logic                 SRC_PRINTER_PORT,
   input  wire logic                 SRC_FLOPPY_CONTROLLER,
   input  wire logic                 SRC_SERIAL_PORT_A,
   input  wire logic                 SRC_SERIAL_PORT_B,
   input  wire logic                 SRC_HARDWARE_MONITOR,
   input  wire logic                 WATCHDOG_TIMEOUT_N,
   input  wire logic                 SRC_MIDI,
   input  wire logic                 SRC_RING_INDICATE_B,
   // Reset sources
   input  wire logic                 POWER_GOOD_OUT,
   input  wire logic                 LPC_RESET_N,
   // Outputs
   output logic                      WAKE_REQ_N,
   output pwea_pkg::pwea_rst_t       RESET_OUT_N,
   output logic                      HM_RESET_N,
   output logic [3:0]                WAKE_IRQ_SEL,
   output logic                      DEV_ACTIVE,
   output logic                      INTR
);
   import pwea_pkg::*;

   // ************************************************************
   // Input synchronisers
   // ************************************************************
   pwea_src_lo_t src_lo_s;
   pwea_src_hi_t src_hi_s;
   logic         wdt_n_s;
   logic         src_hm_s;
   logic         src_midi_s;
   logic         src_rib_s;
   logic         pgood_s;
   logic         lrst_n_s;

   pwea_sync #(.W(`PWEA_STAT_LO_W), .INIT('0)) u_sync_lo (
      .clk   (CLK),
      .rst_n (NRST),
      .d     ({SRC_MOUSE, SRC_KEYBOARD_CONTROLLER, SRC_PRINTER_PORT,
               SRC_FLOPPY_CONTROLLER, SRC_SERIAL_PORT_A, SRC_SERIAL_PORT_B}),
      .q     (src_lo_s)
   );

   // The watchdog line idles high, so its chain resets high too.
   pwea_sync #(.W(6), .INIT(6'h10)) u_sync_hi (
      .clk   (CLK),
      .rst_n (NRST),
      .d     ({SRC_HARDWARE_MONITOR, WATCHDOG_TIMEOUT_N, SRC_MIDI,
               SRC_RING_INDICATE_B, POWER_GOOD_OUT, LPC_RESET_N}),
      .q     ({src_hm_s, wdt_n_s, src_midi_s, src_rib_s, pgood_s, lrst_n_s})
   );

   assign src_hi_s = {src_hm_s, ~wdt_n_s, src_midi_s, src_rib_s};

   // ************************************************************
   // APB decode
   // ************************************************************
   pwea_byte_t idx;
   pwea_byte_t wdat;
   logic       setup;
   logic       access;
   logic       wr_en;
   logic       sel_act;
   logic       sel_irq;
   logic       sel_hms;
   logic       sel_ctrl;
   logic       sel_st_lo;
   logic       sel_st_hi;
   logic       sel_en_lo;
   logic       sel_en_hi;
   logic       sel_istat;
   logic       sel_ien;
   logic       sel_iclr;
   logic       hit;

   assign idx       = PADDR[9:2];
   assign wdat      = PWDATA[7:0];
   assign setup     = PSEL & ~PENABLE;
   assign access    = PSEL & PENABLE;
   assign sel_act   = (idx == `PWEA_IDX_ACTIVATE);
   assign sel_irq   = (idx == `PWEA_IDX_IRQ_SEL);
   assign sel_hms   = (idx == `PWEA_IDX_HM_RST_SEL);
   assign sel_ctrl  = (idx == `PWEA_IDX_RST_CTRL);
   assign sel_st_lo = (idx == `PWEA_IDX_STAT_LO);
   assign sel_st_hi = (idx == `PWEA_IDX_STAT_HI);
   assign sel_en_lo = (idx == `PWEA_IDX_EN_LO);
   assign sel_en_hi = (idx == `PWEA_IDX_EN_HI);
   assign sel_istat = (idx == `PWEA_IDX_INT_STAT);
   assign sel_ien   = (idx == `PWEA_IDX_INT_EN);
   assign sel_iclr  = (idx == `PWEA_IDX_INT_CLR);
   assign hit       = |{sel_act, sel_irq, sel_hms, sel_ctrl, sel_st_lo, sel_st_hi,
                        sel_en_lo, sel_en_hi, sel_istat, sel_ien, sel_iclr};
   // Zero wait states keep the slave simple; read data is caught at setup.
   assign PREADY    = 1'b1;
   assign PSLVERR   = access & ~hit;
   assign wr_en     = access & PWRITE & hit;

   // ************************************************************
   // Standby power registers
   // ************************************************************
   pwea_byte_t   ctrl_q;
   pwea_src_lo_t stat_lo_q;
   pwea_src_hi_t stat_hi_q;
   pwea_src_lo_t en_lo_q;
   pwea_src_hi_t en_hi_q;
   logic         hm_sel_q;
   pwea_src_lo_t stat_lo_d;
   pwea_src_hi_t stat_hi_d;

   assign stat_lo_d = (stat_lo_q & ~({`PWEA_STAT_LO_W{wr_en & sel_st_lo}}
                      & wdat[`PWEA_STAT_LO_W-1:0])) | src_lo_s;
   assign stat_hi_d = (stat_hi_q & ~({`PWEA_STAT_HI_W{wr_en & sel_st_hi}}
                      & wdat[`PWEA_STAT_HI_W-1:0])) | src_hi_s;

   always_ff @(posedge CLK or negedge STBY_NRST)
   begin
      if (!STBY_NRST)
      begin
         ctrl_q    <= `PWEA_RST_CTRL_INIT;
         stat_lo_q <= '0;
         stat_hi_q <= '0;
         en_lo_q   <= '0;
         en_hi_q   <= '0;
         hm_sel_q  <= 1'b0;
      end
      else
      begin
         stat_lo_q <= stat_lo_d;
         stat_hi_q <= stat_hi_d;
         if (wr_en & sel_ctrl)
            ctrl_q <= wdat & `PWEA_RST_CTRL_MASK;
         if (wr_en & sel_en_lo)
            en_lo_q <= wdat[`PWEA_STAT_LO_W-1:0];
         if (wr_en & sel_en_hi)
            en_hi_q <= wdat[`PWEA_STAT_HI_W-1:0];
         if (wr_en & sel_hms)
            hm_sel_q <= wdat[`PWEA_HM_SEL_BIT];
      end
   end

   // ************************************************************
   // Main power registers
   // ************************************************************
   logic       act_q;
   logic [3:0] irq_sel_q;
   pwea_int_t  istat_q;
   pwea_int_t  ien_q;
   pwea_int_t  istat_set;
   pwea_int_t  istat_clr;
   logic       wake_req;
   logic       wake_req_q;

   assign wake_req  = ctrl_q[`PWEA_CTRL_GWE]
                      & (|(stat_lo_q & en_lo_q) | |(stat_hi_q & en_hi_q));
   assign istat_set = {PSLVERR, wake_req & ~wake_req_q};
   assign istat_clr = {`PWEA_INT_W{wr_en & sel_iclr}} & wdat[`PWEA_INT_W-1:0];

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         act_q      <= 1'b0;
         irq_sel_q  <= '0;
         istat_q    <= '0;
         ien_q      <= '0;
         wake_req_q <= 1'b0;
      end
      else
      begin
         if (wr_en & sel_act)
            act_q <= wdat[`PWEA_ACT_BIT];
         if (wr_en & sel_irq)
            irq_sel_q <= wdat[`PWEA_IRQ_SEL_W-1:0];
         if (wr_en & sel_ien)
            ien_q <= wdat[`PWEA_INT_W-1:0];
         istat_q    <= (istat_q & ~istat_clr) | istat_set;
         wake_req_q <= wake_req;
      end
   end

   // ************************************************************
   // Read path
   // ************************************************************
   pwea_byte_t rd_mux;

   assign rd_mux = ({8{sel_act}}   & {7'h00, act_q})
                 | ({8{sel_irq}}   & {4'h0, irq_sel_q})
                 | ({8{sel_hms}}   & {7'h00, hm_sel_q})
                 | ({8{sel_ctrl}}  & ctrl_q)
                 | ({8{sel_st_lo}} & {2'h0, stat_lo_q})
                 | ({8{sel_st_hi}} & {4'h0, stat_hi_q})
                 | ({8{sel_en_lo}} & {2'h0, en_lo_q})
                 | ({8{sel_en_hi}} & {4'h0, en_hi_q})
                 | ({8{sel_istat}} & {6'h00, istat_q})
                 | ({8{sel_ien}}   & {6'h00, ien_q});

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         PRDATA <= '0;
      else if (setup)
         PRDATA <= {24'h000000, rd_mux};
   end

   // ************************************************************
   // Output stage
   // ************************************************************
   pwea_rst_t rst_en;
   logic      hm_rst_src;

   assign rst_en     = ctrl_q[`PWEA_CTRL_RST_LSB +: `PWEA_RST_OUT_N];
   assign hm_rst_src = hm_sel_q ? lrst_n_s : pgood_s;

   // Disabled reset outputs rest high outside NRST reset, which drives every RESET_OUT_N bit low.
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         WAKE_REQ_N   <= 1'b1;
         RESET_OUT_N  <= '0;
         HM_RESET_N   <= 1'b0;
         WAKE_IRQ_SEL <= '0;
         DEV_ACTIVE   <= 1'b0;
         INTR         <= 1'b0;
      end
      else
      begin
         WAKE_REQ_N   <= ~wake_req;
         RESET_OUT_N  <= ~rst_en | {`PWEA_RST_OUT_N{lrst_n_s}};
         HM_RESET_N   <= hm_rst_src;
         WAKE_IRQ_SEL <= irq_sel_q;
         DEV_ACTIVE   <= act_q;
         INTR         <= |(istat_q & ien_q);
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST || !STBY_NRST);

   property p_wake_on;
      NRST && wake_req |=> !WAKE_REQ_N;
   endproperty
   a_wake_on : assert property (p_wake_on)
      else $error("wake request not asserted");

   property p_global_off;
      !ctrl_q[`PWEA_CTRL_GWE] |=> WAKE_REQ_N;
   endproperty
   a_global_off : assert property (p_global_off)
      else $error("wake asserted while globally disabled");

   property p_w1c;
      wr_en && sel_st_lo |=>
         ((stat_lo_q & $past(wdat[5:0]) & ~$past(src_lo_s)) == 6'h00);
   endproperty
   a_w1c : assert property (p_w1c)
      else $error("status bit survived write one clear");

   property p_sticky;
      !(wr_en && sel_st_lo) |=> ((stat_lo_q & $past(stat_lo_q)) == $past(stat_lo_q));
   endproperty
   a_sticky : assert property (p_sticky)
      else $error("status bit lost without a clear");

   property p_hi_set;
      1'b1 |=> ((stat_hi_q & $past(src_hi_s)) == $past(src_hi_s));
   endproperty
   a_hi_set : assert property (p_hi_set)
      else $error("high status missed an event");

   property p_rst_off;
      NRST && !ctrl_q[`PWEA_CTRL_RST_LSB] |=> RESET_OUT_N[0];
   endproperty
   a_rst_off : assert property (p_rst_off)
      else $error("disabled reset output asserted");

   property p_hm_sel;
      hm_sel_q && $stable(hm_sel_q) |=> (HM_RESET_N == $past(lrst_n_s));
   endproperty
   a_hm_sel : assert property (p_hm_sel)
      else $error("monitor reset not from bus reset");

   property p_en_write;
      wr_en && sel_en_lo |=> (en_lo_q == $past(wdat[5:0]));
   endproperty
   a_en_write : assert property (p_en_write)
      else $error("low enable write lost");

   property p_reserved;
      setup && sel_ctrl |=> (PRDATA[31:8] == 24'h000000) && !PRDATA[7] && !PRDATA[1];
   endproperty
   a_reserved : assert property (p_reserved)
      else $error("reserved control bits read non zero");

   sequence s_bad_access;
      PSEL && PENABLE && !hit && ien_q[`PWEA_INT_BUSERR];
   endsequence
   sequence s_irq_raise;
      istat_q[`PWEA_INT_BUSERR] ##1 INTR;
   endsequence
   property p_buserr_irq;
      s_bad_access |=> s_irq_raise;
   endproperty
   a_buserr_irq : assert property (p_buserr_irq)
      else $error("bus error did not raise interrupt");

endmodule // pwea_top

/* bench/pwea_host_model.sv */
// Host-side receiver of the active-low wake request.
// Assumes the request is a level that the device holds until software clears the cause.
`timescale 1ns/1ns

module pwea_host_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Wake request from the device
   input  wire logic       wake_req_n,
   // Count of wake requests seen
   output logic      [7:0] wake_cnt
);
   logic prev_q;

   // A held request counts once; only a new assertion is a new wake.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prev_q   <= 1'b1;
         wake_cnt <= 8'h00;
      end
      else
      begin
         prev_q <= wake_req_n;
         if (prev_q && !wake_req_n)
            wake_cnt <= wake_cnt + 8'h01;
      end
   end
endmodule // pwea_host_model

/* bench/tb_top.sv */
// Self-checking bench of the wake event aggregator: APB tasks and directed tests.
// Assumes the design files and the host model are compiled first.
`timescale 1ns/1ns

module tb_top;
   import pwea_pkg::*;

   // ************************************************************
   // Signals
   // ************************************************************
   logic       clk = 1'b0, nrst = 1'b0, snrst = 1'b0;
   logic       psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [9:0] paddr = 10'h000;
   pwea_word_t pwdata = 32'h0, prdata, rd_q;
   logic       pready, pslverr, err_q;
   logic [9:0] src = 10'h000;
   logic       pg = 1'b1, lpc_n = 1'b1;
   logic       wake_n, hm_n, act, intr;
   pwea_rst_t  rst_out;
   logic [3:0] irq_sel;
   logic [7:0] wake_cnt;
   int         error_cnt = 0, n_checks = 0, cyc = 0;

   always #20 clk = ~clk;

   pwea_top uut (.CLK(clk), .NRST(nrst), .STBY_NRST(snrst), .PSEL(psel), .PENABLE(pen),
      .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .SRC_MOUSE(src[5]), .SRC_KEYBOARD_CONTROLLER(src[4]),
      .SRC_PRINTER_PORT(src[3]), .SRC_FLOPPY_CONTROLLER(src[2]), .SRC_SERIAL_PORT_A(src[1]),
      .SRC_SERIAL_PORT_B(src[0]), .SRC_HARDWARE_MONITOR(src[9]), .WATCHDOG_TIMEOUT_N(~src[8]),
      .SRC_MIDI(src[7]), .SRC_RING_INDICATE_B(src[6]), .POWER_GOOD_OUT(pg),
      .LPC_RESET_N(lpc_n), .WAKE_REQ_N(wake_n), .RESET_OUT_N(rst_out), .HM_RESET_N(hm_n),
      .WAKE_IRQ_SEL(irq_sel), .DEV_ACTIVE(act), .INTR(intr));

   pwea_host_model host (.clk(clk), .rst_n(nrst), .wake_req_n(wake_n), .wake_cnt(wake_cnt));

   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         $display("unexpected %s expected %h seen %h", n, e, g);
         error_cnt++;
      end
   endtask

   // The request is held until pready is seen high at a rising edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      psel   <= 1'b1;
      pen    <= 1'b0;
      pwr    <= w;
      paddr  <= {a, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rd_q  = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      pen  <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
      apb(1'b0, a, 8'h00);
      chk(n, {24'h0, e}, rd_q);
   endtask

   task automatic w(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic pulse(input int i);
      @(posedge clk);
      src[i] <= 1'b1;
      repeat (4) @(posedge clk);
      src[i] <= 1'b0;
   endtask

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         wrap_up();
      end
   end

   // ************************************************************
   // Tests
   // ************************************************************
   initial
   begin
      logic [7:0] a, m;
      int         wc;
      repeat (8) @(posedge clk);
      nrst  <= 1'b1;
      snrst <= 1'b1;
      w(4);
      rd(8'hf2, 8'h7c, "ctrl reset");
      rd(8'hf3, 8'h00, "stat lo reset");
      rd(8'hf4, 8'h00, "stat hi reset");
      rd(8'hf6, 8'h00, "en lo reset");
      rd(8'hf7, 8'h00, "en hi reset");
      rd(8'h30, 8'h00, "act reset");
      chk("reset outs idle", 32'h1f, rst_out);
      $display("test reset values done");

      apb(1'b1, 8'hf2, 8'hff);
      rd(8'hf2, 8'h7d, "ctrl reserved");
      apb(1'b1, 8'hf6, 8'hff);
      rd(8'hf6, 8'h3f, "en lo reserved");
      apb(1'b1, 8'hf7, 8'hff);
      rd(8'hf7, 8'h0f, "en hi reserved");
      $display("test reserved bits done");

      // Every source in turn: latch, hold after the event, wake, then clear.
      for (int i = 0; i < 10; i++)
      begin
         a = (i < 6) ? 8'hf3 : 8'hf4;
         m = 8'h01 << ((i < 6) ? i : i - 6);
         wc = wake_cnt;
         pulse(i);
         rd(a, m, "status latch");
         chk("wake asserted", 32'h0, wake_n);
         apb(1'b1, a, m);
         rd(a, 8'h00, "status cleared");
         chk("wake released", 32'h1, wake_n);
         chk("host wake count", wc + 1, wake_cnt);
      end
      $display("test event sources done");

      apb(1'b1, 8'hf2, 8'h7c);
      apb(1'b1, 8'hf6, 8'h20);
      pulse(5);
      w(3);
      chk("global off", 32'h1, wake_n);
      apb(1'b1, 8'hf2, 8'h7d);
      w(2);
      chk("global on", 32'h0, wake_n);
      apb(1'b1, 8'hf6, 8'h20);
      apb(1'b1, 8'hf3, 8'h20);
      apb(1'b1, 8'hf6, 8'h1f);
      pulse(5);
      w(3);
      chk("source masked", 32'h1, wake_n);
      rd(8'hf3, 8'h20, "masked still latched");
      apb(1'b1, 8'hf3, 8'h20);
      $display("test enables done");

      @(posedge clk) lpc_n <= 1'b0;
      w(5);
      chk("reset outs active", 32'h00, rst_out);
      chk("hm from power good", 32'h1, hm_n);
      apb(1'b1, 8'hf2, 8'h79);
      apb(1'b1, 8'he7, 8'h01);
      w(4);
      chk("reset out 0 off", 32'h01, rst_out);
      chk("hm from bus reset", 32'h0, hm_n);
      @(posedge clk) pg <= 1'b0;
      lpc_n <= 1'b1;
      w(5);
      chk("hm ignores power good", 32'h1, hm_n);
      chk("reset outs idle", 32'h1f, rst_out);
      $display("test reset outputs done");

      apb(1'b1, 8'h70, 8'hff);
      apb(1'b1, 8'h30, 8'hff);
      rd(8'h70, 8'h0f, "irq sel read");
      rd(8'h30, 8'h01, "act read");
      chk("irq sel out", 32'hf, irq_sel);
      chk("act out", 32'h1, act);
      @(posedge clk) nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      w(3);
      chk("act after reset", 32'h0, act);
      rd(8'hf2, 8'h79, "ctrl kept");
      rd(8'hf6, 8'h1f, "en lo kept");
      rd(8'hf7, 8'h0f, "en hi kept");
      $display("test standby domain done");

      apb(1'b1, 8'hd2, 8'h03);
      apb(1'b1, 8'hd1, 8'h02);
      apb(1'b0, 8'h00, 8'h00);
      chk("unmapped error", 32'h1, err_q);
      w(3);
      chk("intr raised", 32'h1, intr);
      rd(8'hd0, 8'h02, "int status");
      apb(1'b1, 8'hd2, 8'h02);
      w(3);
      chk("intr cleared", 32'h0, intr);
      apb(1'b1, 8'hd1, 8'h00);
      apb(1'b1, 8'h01, 8'h55);
      w(3);
      chk("intr masked", 32'h0, intr);
      rd(8'hd0, 8'h02, "masked status");
      $display("test interrupt done");
      wrap_up();
   end
endmodule // tb_top
